// ---- rtl/ptk_pkg.sv ----
// package: constants and types for process timers and peak tracker
package ptk_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_PERIOD_S  = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned DEBOUNCE_MS    = 20;
  localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned LABEL_MS       = 1000;
  localparam int unsigned LABEL_CYC      = (CLK_HZ / 1000) * LABEL_MS;
  localparam int unsigned TMR_MAX_S      = 99999;
  localparam int unsigned TMR_W          = 17;
  localparam logic [9:0]  HOURS_MAX      = 10'h3E7;
  localparam logic [5:0]  MINSEC_MAX     = 6'h3B;
  localparam logic [1:0]  TMODE_START    = 2'h0;
  localparam logic [1:0]  TMODE_PULSE    = 2'h1;
  localparam logic [1:0]  TMODE_DELAY    = 2'h2;
  typedef enum logic [3:0] {
    PTK_DISP_PROCESS  = 4'h0,
    PTK_DISP_EL_LABEL = 4'h1,
    PTK_DISP_ELAPSED  = 4'h2,
    PTK_DISP_T1_LABEL = 4'h3,
    PTK_DISP_T1       = 4'h4,
    PTK_DISP_T2_LABEL = 4'h5,
    PTK_DISP_T2       = 4'h6,
    PTK_DISP_HI_LABEL = 4'h7,
    PTK_DISP_HI       = 4'h8,
    PTK_DISP_LO_LABEL = 4'h9,
    PTK_DISP_LO       = 4'hA
  } ptk_disp_e;
endpackage

// ---- rtl/ptk_process_timers.sv ----
// top: two timers, elapsed counter, peaks, keypad selection, alarm outputs
// Functional notes
// - timer key twice and held shows timer 1 left; reset restarts it.
// - timer key thrice and held shows timer 2 left; reset restarts it.
// - mode 0 times from power-up or reset, output on when done.
// - mode 1 output on at limit, held for duration, then off.
// - mode 2 starts timing at limit, output on when duration passes.
// - timer 1 follows limit 1, timer 2 follows limit 2.
// - elapsed kept as hours up to 999, minutes and seconds to 59.
// - elapsed counts from power-up or last reset.
// - one time press shows elapsed label then value.
// - timer held plus reset shows elapsed briefly, then clears to zero.
// - highest and lowest readings kept since power-up or peak reset.
// - data press one shows high label/value, press two low label/value.
// - reset while high shown and data held loads current reading.
// - reset while low shown and data held loads current reading.
// - each alarm output has selectable closing or opening polarity.
// - status LED lit exactly while its alarm is active.
// - timer durations accepted from 1 to 99999 seconds.
`timescale 1ns/1ps
module ptk_process_timers
  import ptk_pkg::*;
#(
  parameter int          PW        = 16,
  parameter int unsigned TICK_CYC  = TICK_CYCLES,
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned LBL_CYC   = LABEL_CYC
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              time_key,
  input  wire logic              data_key,
  input  wire logic              reset_key,
  input  wire logic signed [PW-1:0] process_value,
  input  wire logic              limit1_hit,
  input  wire logic              limit2_hit,
  input  wire logic [1:0]        timer1_mode,
  input  wire logic [1:0]        timer2_mode,
  input  wire logic [TMR_W-1:0]  timer1_duration,
  input  wire logic [TMR_W-1:0]  timer2_duration,
  input  wire logic [3:0]        alarm_active_in,
  input  wire logic [5:0]        alarm_opening,
  output logic [5:0]             alarm_out,
  output logic [5:0]             alarm_led,
  output logic [3:0]             disp_sel,
  output logic [31:0]            disp_value,
  output logic [9:0]             elapsed_hours,
  output logic [5:0]             elapsed_minutes,
  output logic [5:0]             elapsed_seconds,
  output logic signed [PW-1:0]   high_peak,
  output logic signed [PW-1:0]   low_peak
);
  localparam int KN = 3;

  // debounced key levels and press edges
  logic [KN-1:0] key_raw;
  logic [KN-1:0] key_lvl_reg;
  logic [KN-1:0] key_prev_reg;
  logic [KN-1:0] key_press;
  logic [31:0]   deb_cnt_reg [KN];
  assign key_raw   = {reset_key, data_key, time_key};
  assign key_press = key_lvl_reg & ~key_prev_reg;

  genvar gi;
  generate
    for (gi = 0; gi < KN; gi++)
    begin : g_deb
      // a level must stay different for the debounce time before it is taken
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          deb_cnt_reg[gi] <= '0;
          key_lvl_reg[gi] <= 1'b0;
          key_prev_reg[gi] <= 1'b0;
        end
        else
        begin
          key_prev_reg[gi] <= key_lvl_reg[gi];
          if (key_raw[gi] == key_lvl_reg[gi])
            deb_cnt_reg[gi] <= '0;
          else if (deb_cnt_reg[gi] >= DEB_CYC - 1)
          begin
            deb_cnt_reg[gi] <= '0;
            key_lvl_reg[gi] <= key_raw[gi];
          end
          else
            deb_cnt_reg[gi] <= deb_cnt_reg[gi] + 32'h1;
        end
      end
    end
  endgenerate

  logic time_held;
  logic data_held;
  logic time_press;
  logic data_press;
  logic rst_press;
  assign time_held  = key_lvl_reg[0];
  assign data_held  = key_lvl_reg[1];
  assign time_press = key_press[0];
  assign data_press = key_press[1];
  assign rst_press  = key_press[2];

  // one-second tick
  logic [31:0] tick_cnt_reg;
  logic        tick;
  assign tick = (tick_cnt_reg == TICK_CYC - 1);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
  end

  // display selection state
  ptk_disp_e   disp_reg;
  ptk_disp_e   disp_next;
  logic [31:0] lbl_cnt_reg;
  logic        lbl_done;
  logic        is_label;
  logic        el_clear_pend_reg;
  assign lbl_done = (lbl_cnt_reg >= LBL_CYC - 1);
  assign is_label = disp_reg inside {PTK_DISP_EL_LABEL, PTK_DISP_T1_LABEL,
                    PTK_DISP_T2_LABEL, PTK_DISP_HI_LABEL, PTK_DISP_LO_LABEL};

  // reset actions, valid only while the selecting key is held
  logic t1_restart;
  logic t2_restart;
  logic el_reset_req;
  logic hi_load;
  logic lo_load;
  assign t1_restart   = rst_press && time_held && disp_reg == PTK_DISP_T1;
  assign t2_restart   = rst_press && time_held && disp_reg == PTK_DISP_T2;
  assign el_reset_req = rst_press && time_held && disp_reg == PTK_DISP_ELAPSED;
  assign hi_load      = rst_press && data_held && disp_reg == PTK_DISP_HI;
  assign lo_load      = rst_press && data_held && disp_reg == PTK_DISP_LO;

  // next display: a time key press steps the sequence, else a data key press does; labels time out
  always_comb
  begin
    disp_next = disp_reg;
    if (time_press)
    begin
      unique case (disp_reg)
        PTK_DISP_EL_LABEL, PTK_DISP_ELAPSED: disp_next = PTK_DISP_T1_LABEL;
        PTK_DISP_T1_LABEL, PTK_DISP_T1:      disp_next = PTK_DISP_T2_LABEL;
        default:                             disp_next = PTK_DISP_EL_LABEL;
      endcase
    end
    else if (data_press)
    begin
      if (disp_reg == PTK_DISP_HI_LABEL || disp_reg == PTK_DISP_HI)
        disp_next = PTK_DISP_LO_LABEL;
      else
        disp_next = PTK_DISP_HI_LABEL;
    end
    else if (is_label && lbl_done)
      disp_next = ptk_disp_e'(disp_reg + 4'h1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disp_reg    <= PTK_DISP_PROCESS;
      lbl_cnt_reg <= '0;
    end
    else
    begin
      disp_reg    <= disp_next;
      lbl_cnt_reg <= (disp_next != disp_reg || el_reset_req) ? 32'h0 : lbl_cnt_reg + 32'h1;
    end
  end

  // pending clear: the old elapsed value stays visible for one label time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      el_clear_pend_reg <= 1'b0;
    else if (el_reset_req)
      el_clear_pend_reg <= 1'b1;
    else if (lbl_done)
      el_clear_pend_reg <= 1'b0;
  end

  // elapsed run time, hours:minutes:seconds, saturating
  logic [9:0] hr_reg;
  logic [5:0] mn_reg;
  logic [5:0] sc_reg;
  logic       el_max;
  logic       el_clear;
  assign el_max   = hr_reg == HOURS_MAX && mn_reg == MINSEC_MAX && sc_reg == MINSEC_MAX;
  assign el_clear = el_clear_pend_reg && lbl_done;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hr_reg <= '0;
      mn_reg <= '0;
      sc_reg <= '0;
    end
    else if (el_clear)
    begin
      hr_reg <= '0;
      mn_reg <= '0;
      sc_reg <= '0;
    end
    else if (tick && !el_max)
    begin
      sc_reg <= (sc_reg == MINSEC_MAX) ? 6'h0 : sc_reg + 6'h1;
      if (sc_reg == MINSEC_MAX)
      begin
        mn_reg <= (mn_reg == MINSEC_MAX) ? 6'h0 : mn_reg + 6'h1;
        if (mn_reg == MINSEC_MAX)
          hr_reg <= hr_reg + 10'h1;
      end
    end
  end

  // peak tracking
  logic signed [PW-1:0] hi_reg;
  logic signed [PW-1:0] lo_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_reg <= {1'b1, {(PW-1){1'b0}}};                    // lowest signed value
      lo_reg <= {1'b0, {(PW-1){1'b1}}};                    // highest signed value
    end
    else
    begin
      if (hi_load)
        hi_reg <= process_value;
      else if (process_value > hi_reg)
        hi_reg <= process_value;
      if (lo_load)
        lo_reg <= process_value;
      else if (process_value < lo_reg)
        lo_reg <= process_value;
    end
  end

  // durations clamped to 1..99999 seconds
  logic [TMR_W-1:0] dur1;
  logic [TMR_W-1:0] dur2;
  logic [TMR_W-1:0] rem1;
  logic [TMR_W-1:0] rem2;
  logic             t1_act;
  logic             t2_act;
  function automatic logic [TMR_W-1:0] clamp_dur(input logic [TMR_W-1:0] d);
    if (d == '0)
      return TMR_W'(1);
    else if (d > TMR_W'(TMR_MAX_S))
      return TMR_W'(TMR_MAX_S);
    else
      return d;
  endfunction
  assign dur1 = clamp_dur(timer1_duration);
  assign dur2 = clamp_dur(timer2_duration);

  // timer 1 on limit 1, timer 2 on limit 2
  ptk_timer #(.W(TMR_W)) u_timer1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .restart   (t1_restart),
    .mode      (timer1_mode),
    .duration  (dur1),
    .limit_hit (limit1_hit),
    .remain    (rem1),
    .active    (t1_act)
  );
  ptk_timer #(.W(TMR_W)) u_timer2 (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .restart   (t2_restart),
    .mode      (timer2_mode),
    .duration  (dur2),
    .limit_hit (limit2_hit),
    .remain    (rem2),
    .active    (t2_act)
  );

  // alarm vector, polarity and LED
  logic [5:0]  alm_act;
  logic [31:0] disp_val_next;
  assign alm_act = {t2_act, t1_act, alarm_active_in};
  always_comb
  begin
    unique case (disp_reg)
      PTK_DISP_ELAPSED: disp_val_next = {10'h0, hr_reg, mn_reg, sc_reg};
      PTK_DISP_T1:      disp_val_next = 32'(rem1);
      PTK_DISP_T2:      disp_val_next = 32'(rem2);
      PTK_DISP_HI:      disp_val_next = 32'(signed'(hi_reg));
      PTK_DISP_LO:      disp_val_next = 32'(signed'(lo_reg));
      default:          disp_val_next = 32'(signed'(process_value));
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_out  <= '0;
      alarm_led  <= '0;
      disp_sel   <= 4'h0;
      disp_value <= '0;
    end
    else
    begin
      alarm_out  <= alm_act ^ alarm_opening;
      alarm_led  <= alm_act;
      disp_sel   <= disp_reg;
      disp_value <= disp_val_next;
    end
  end
  assign elapsed_hours   = hr_reg;
  assign elapsed_minutes = mn_reg;
  assign elapsed_seconds = sc_reg;
  assign high_peak       = hi_reg;
  assign low_peak        = lo_reg;

  a_led_follows: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 alarm_led == $past(alm_act))
    else $error("status led does not follow alarm");
  a_polarity_out: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 alarm_out == ($past(alm_act) ^ $past(alarm_opening)))
    else $error("alarm polarity wrong");
  a_el_saturate: assert property (@(posedge clk) disable iff (!rst_n)
    el_max && !el_clear |=> el_max)
    else $error("elapsed counter wrapped");
  a_fields_range: assert property (@(posedge clk) disable iff (!rst_n)
    mn_reg <= MINSEC_MAX && sc_reg <= MINSEC_MAX && hr_reg <= HOURS_MAX)
    else $error("elapsed field out of range");
  a_el_clear_zero: assert property (@(posedge clk) disable iff (!rst_n)
    el_clear |=> hr_reg == 10'h0 && mn_reg == 6'h0 && sc_reg == 6'h0)
    else $error("elapsed not cleared");
  a_hi_load_now: assert property (@(posedge clk) disable iff (!rst_n)
    hi_load |=> hi_reg == $past(process_value))
    else $error("high peak not loaded");
  a_lo_load_now: assert property (@(posedge clk) disable iff (!rst_n)
    lo_load |=> lo_reg == $past(process_value))
    else $error("low peak not loaded");
  a_peak_track: assert property (@(posedge clk) disable iff (!rst_n)
    !hi_load && !lo_load |=> hi_reg >= $past(process_value) && lo_reg <= $past(process_value))
    else $error("peak missed a reading");
  a_restart_reload: assert property (@(posedge clk) disable iff (!rst_n)
    t1_restart |=> !t1_act && rem1 == $past(dur1))
    else $error("timer 1 restart did not reload");
  a_press_step: assert property (@(posedge clk) disable iff (!rst_n)
    time_press && disp_reg inside {PTK_DISP_PROCESS, PTK_DISP_T2_LABEL, PTK_DISP_T2,
    PTK_DISP_HI_LABEL, PTK_DISP_HI, PTK_DISP_LO_LABEL, PTK_DISP_LO}
    |=> disp_reg == PTK_DISP_EL_LABEL)
    else $error("time press did not show label");
  c_t1_restart: cover property (@(posedge clk) disable iff (!rst_n) t1_restart);
  c_el_clear:   cover property (@(posedge clk) disable iff (!rst_n) el_clear);
  c_lo_load:    cover property (@(posedge clk) disable iff (!rst_n) lo_load);
  c_t2_on:      cover property (@(posedge clk) disable iff (!rst_n) t2_act);
endmodule // ptk_process_timers

// ---- rtl/ptk_timer.sv ----
// one programmable process timer with three modes
`timescale 1ns/1ps
module ptk_timer
  import ptk_pkg::*;
#(
  parameter int W = TMR_W
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         restart,
  input  wire logic [1:0]   mode,
  input  wire logic [W-1:0] duration,
  input  wire logic         limit_hit,
  output logic [W-1:0]      remain,
  output logic              active
);
  logic [W-1:0] remain_reg;
  logic         run_reg;
  logic         wait_reg;
  logic         act_reg;
  logic         start;
  logic         done;

  // start when limit reached in limit-dependent modes
  assign start = wait_reg && (mode == TMODE_START || limit_hit);
  assign done  = run_reg && tick && remain_reg <= W'(1);

  // countdown state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain_reg <= '0;
      run_reg    <= 1'b0;
      wait_reg   <= 1'b1;
      act_reg    <= 1'b0;
    end
    else if (restart)
    begin
      remain_reg <= duration;
      run_reg    <= 1'b0;
      wait_reg   <= 1'b1;
      act_reg    <= 1'b0;
    end
    else if (start)
    begin
      remain_reg <= duration;
      run_reg    <= 1'b1;
      wait_reg   <= 1'b0;
      act_reg    <= (mode == TMODE_PULSE);
    end
    else if (done)
    begin
      remain_reg <= '0;
      run_reg    <= 1'b0;
      act_reg    <= (mode != TMODE_PULSE);
    end
    else if (run_reg && tick)
    begin
      remain_reg <= remain_reg - W'(1);
    end
  end

  assign remain = remain_reg;
  assign active = act_reg;

  a_pulse_ends: assert property (@(posedge clk) disable iff (!rst_n)
    done && mode == TMODE_PULSE && !restart |=> !act_reg)
    else $error("pulse mode output did not drop at end");
endmodule // ptk_timer

// ---- tb/ptk_panel_model.sv ----
// front-panel keypad model: timer, data and reset keys pressed by the bench
`timescale 1ns/1ps
module ptk_panel_model (
  input  wire logic clk,
  output logic      time_key,
  output logic      data_key,
  output logic      reset_key
);
  localparam int KEY_TIME  = 0;
  localparam int KEY_DATA  = 1;
  localparam int KEY_RESET = 2;
  localparam int HOLD_CYC  = 6;

  // keys rest released; a released button reads low through its pull-down
  initial
  begin
    time_key  = 1'b0;
    data_key  = 1'b0;
    reset_key = 1'b0;
  end

  // move one key level just after a rising edge
  task automatic set_key(input int which, input logic lvl);
    @(posedge clk);
    #1;
    case (which)
      KEY_TIME: time_key  = lvl;
      KEY_DATA: data_key  = lvl;
      default:  reset_key = lvl;
    endcase
  endtask

  // one press, held long enough to pass the debounce filter, then released
  task automatic tap_key(input int which);
    set_key(which, 1'b1);
    repeat (HOLD_CYC) @(posedge clk);
    set_key(which, 1'b0);
    repeat (HOLD_CYC) @(posedge clk);
    #1;
  endtask
endmodule // ptk_panel_model

// ---- tb/ptk_process_timers_test.sv ----
// self-checking bench for the process timers and peak tracker
`timescale 1ns/1ps
module ptk_process_timers_test;
  import ptk_pkg::*;
  localparam int PW = 16;
  localparam int TK = 10;
  localparam int DB = 2;
  localparam int LB = 4;
  logic                 clk;
  logic                 rst_n;
  wire logic            time_key;
  wire logic            data_key;
  wire logic            reset_key;
  logic signed [PW-1:0] process_value;
  logic                 limit1_hit;
  logic                 limit2_hit;
  logic [1:0]           timer1_mode;
  logic [1:0]           timer2_mode;
  logic [TMR_W-1:0]     timer1_duration;
  logic [TMR_W-1:0]     timer2_duration;
  logic [3:0]           alarm_active_in;
  logic [5:0]           alarm_opening;
  logic [5:0]           alarm_out;
  logic [5:0]           alarm_led;
  logic [3:0]           disp_sel;
  logic [31:0]          disp_value;
  logic [9:0]           elapsed_hours;
  logic [5:0]           elapsed_minutes;
  logic [5:0]           elapsed_seconds;
  logic signed [PW-1:0] high_peak;
  logic signed [PW-1:0] low_peak;
  int                   err_total;
  int                   checks_done;
  logic [31:0]          t0;
  logic [3:0]           act_tab [3];
  logic [5:0]           open_tab [3];

  ptk_process_timers #(.PW(PW), .TICK_CYC(TK), .DEB_CYC(DB), .LBL_CYC(LB)) dut (
    .clk(clk), .rst_n(rst_n), .time_key(time_key), .data_key(data_key),
    .reset_key(reset_key), .process_value(process_value), .limit1_hit(limit1_hit),
    .limit2_hit(limit2_hit), .timer1_mode(timer1_mode), .timer2_mode(timer2_mode),
    .timer1_duration(timer1_duration), .timer2_duration(timer2_duration),
    .alarm_active_in(alarm_active_in), .alarm_opening(alarm_opening),
    .alarm_out(alarm_out), .alarm_led(alarm_led), .disp_sel(disp_sel),
    .disp_value(disp_value), .elapsed_hours(elapsed_hours),
    .elapsed_minutes(elapsed_minutes), .elapsed_seconds(elapsed_seconds),
    .high_peak(high_peak), .low_peak(low_peak)
  );

  ptk_panel_model panel (
    .clk(clk), .time_key(time_key), .data_key(data_key), .reset_key(reset_key)
  );

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // advance n edges and land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wait, bounded, for the display selection to reach a value
  task automatic wait_sel(input logic [3:0] v);
    int n;
    n = 0;
    while (disp_sel !== v && n < 80)
    begin
      step(1);
      n++;
    end
    chk("disp_sel", {28'h0, disp_sel}, {28'h0, v});
  endtask

  // elapsed run time in seconds
  function automatic logic [31:0] tot();
    return elapsed_hours * 3600 + elapsed_minutes * 60 + elapsed_seconds;
  endfunction

  // print the counts and the verdict, then stop
  task automatic complete_run();
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short; the tests need well under 3000 cycles
  initial
  begin
    #100us;
    err_total++;
    complete_run();
  end

  // main sequence
  initial
  begin
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    process_value = 16'h0064;
    limit1_hit = 1'b0;
    limit2_hit = 1'b0;
    timer1_mode = TMODE_START;
    timer2_mode = TMODE_PULSE;
    timer1_duration = 17'h00003;
    timer2_duration = 17'h00002;
    alarm_active_in = 4'h0;
    alarm_opening = 6'h00;
    act_tab = '{4'h5, 4'hA, 4'h0};
    open_tab = '{6'h00, 6'h13, 6'h3F};
    step(8);
    rst_n = 1'b1;
    chk("disp_sel_rst", {28'h0, disp_sel}, 32'h0);
    chk("alarm_out_rst", {26'h0, alarm_out}, 32'h0);
    chk("elapsed_rst", tot(), 32'h0);
    step(15);
    chk("t1_early", {31'h0, alarm_out[4]}, 32'h0);
    t0 = tot();
    step(100);
    chk("elapsed_rate", tot(), t0 + 10);
    chk("t1_done", {31'h0, alarm_out[4]}, 32'h1);
    chk("t1_led", {31'h0, alarm_led[4]}, 32'h1);
    // alarm polarity and status lights across a small table
    for (int i = 0; i < 3; i++)
    begin
      alarm_active_in = act_tab[i];
      alarm_opening = open_tab[i];
      step(3);
      chk("alarm_out", {26'h0, alarm_out}, {26'h0, {2'b01, act_tab[i]} ^ open_tab[i]});
      chk("alarm_led", {26'h0, alarm_led}, {26'h0, 2'b01, act_tab[i]});
    end
    alarm_opening = 6'h00;
    // pulse mode on timer 2 ignores limit 1 and follows limit 2
    limit1_hit = 1'b1;
    step(5);
    chk("t2_limit1", {31'h0, alarm_out[5]}, 32'h0);
    limit2_hit = 1'b1;
    step(5);
    chk("t2_pulse_on", {31'h0, alarm_out[5]}, 32'h1);
    step(40);
    chk("t2_pulse_off", {31'h0, alarm_out[5]}, 32'h0);
    limit1_hit = 1'b0;
    limit2_hit = 1'b0;
    // peak tracking
    process_value = 16'h0032;
    step(2);
    process_value = 16'hFFEC;
    step(2);
    process_value = 16'h001E;
    step(2);
    chk("high_peak", {16'h0, high_peak}, 32'h0064);
    chk("low_peak", {16'h0, low_peak}, 32'h0000FFEC);
    panel.set_key(1, 1'b1);
    wait_sel(4'h7);
    wait_sel(4'h8);
    chk("hi_value", disp_value, 32'h00000064);
    panel.tap_key(2);
    step(3);
    chk("hi_reload", {16'h0, high_peak}, 32'h001E);
    chk("hi_shown", disp_value, 32'h0000001E);
    panel.set_key(1, 1'b0);
    step(6);
    panel.set_key(1, 1'b1);
    wait_sel(4'h9);
    wait_sel(4'hA);
    chk("lo_value", disp_value, 32'hFFFFFFEC);
    panel.tap_key(2);
    step(3);
    chk("lo_reload", {16'h0, low_peak}, 32'h001E);
    panel.set_key(1, 1'b0);
    step(6);
    // elapsed clear while the time key is held
    panel.set_key(0, 1'b1);
    wait_sel(4'h1);
    wait_sel(4'h2);
    panel.tap_key(2);
    chk("el_brief", {28'h0, disp_sel}, 32'h2);
    step(LB + 6);
    chk("el_cleared", {31'h0, tot() < 3}, 32'h1);
    panel.set_key(0, 1'b0);
    step(6);
    // timer 1 restarted in delay mode waits for limit 1
    timer1_mode = TMODE_DELAY;
    panel.set_key(0, 1'b1);
    wait_sel(4'h3);
    wait_sel(4'h4);
    panel.tap_key(2);
    step(3);
    chk("t1_restart", {31'h0, alarm_out[4]}, 32'h0);
    chk("t1_left", disp_value, 32'h00000003);
    step(60);
    chk("t1_waiting", {31'h0, alarm_out[4]}, 32'h0);
    limit1_hit = 1'b1;
    step(8);
    chk("t1_delaying", {31'h0, alarm_out[4]}, 32'h0);
    step(40);
    chk("t1_delay_on", {31'h0, alarm_out[4]}, 32'h1);
    panel.set_key(0, 1'b0);
    step(6);
    // timer 2 restart re-arms its pulse
    limit2_hit = 1'b1;
    panel.set_key(0, 1'b1);
    wait_sel(4'h5);
    wait_sel(4'h6);
    panel.tap_key(2);
    step(5);
    chk("t2_rearm", {31'h0, alarm_out[5]}, 32'h1);
    chk("t2_left", disp_value, 32'h00000001);
    step(40);
    chk("t2_rearm_off", {31'h0, alarm_out[5]}, 32'h0);
    panel.set_key(0, 1'b0);
    step(6);
    complete_run();
  end
endmodule // ptk_process_timers_test
